// ### src/aseq_sequencer.sv
// Instruction sequencer with its parallel bus port, config and status words.
// Assumes an analog engine answering acquire, convert and compare requests.
`timescale 1ns/10ps
module aseq_sequencer
    import aseq_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        busChipSel_b,
    input  wire logic        busRead_b,
    input  wire logic        busWrite_b,
    input  wire logic        bus_width_select,
    input  wire logic [4:0]  bus_address_lines,
    input  wire logic [15:0] busDataIn,
    output logic      [15:0] busDataOut,
    output logic             busDataOe,
    input  wire logic        syncPinIn,
    output logic             syncPinOut,
    output logic             syncPinOe,
    input  wire logic [15:0] timerPreset,
    output logic      [2:0]  muxPos,
    output logic      [2:0]  muxNeg,
    output logic             lowRes,
    output logic             wdMode,
    output logic             acqGo,
    input  wire logic        acqDone,
    output logic             convGo,
    input  wire logic        convDone,
    output logic             cmpGo,
    output logic      [15:0] cmpLimit,
    input  wire logic        cmpDone,
    input  wire logic        cmpAbove,
    output logic             pauseIrq,
    output logic             wdIrq
);
    typedef struct packed {
        aseq_state_t      st;
        logic [2:0][2:0]  pinSh;
        logic [2:0]       pinLvl;
        logic [15:0]      cfg;
        logic             pauseFlag;
        logic             wd1Flag;
        logic             wd2Flag;
        logic             firstPass;
        logic [2:0]       idx;
        logic [15:0]      ctl;
        logic [15:0]      timer;
        logic [3:0]       div;
        logic             acqGo;
        logic             convGo;
        logic             cmpGo;
        logic             cmpSel;
        logic [15:0]      cmpLimit;
        logic [15:0]      rdData;
    } aseq_seq_t;

    aseq_seq_t s;
    aseq_seq_t n;
    aseq_mem_if memBus();

    logic [2:0]  pinRaw;
    logic [3:0]  wordAddr;
    logic        isInstr;
    logic [1:0]  ptr;
    logic [1:0]  byteEn;
    logic [15:0] wrWord;
    logic        wrEdge;
    logic        rdEdge;
    logic        syncRise;
    logic        softRst;
    logic        statClr;
    logic        syncWait;
    logic [15:0] rdWord;
    logic [15:0] statWord;

    // Agreement of the second and third stage marks a settled rising level
    function automatic logic pinRise(input logic [2:0] sh, input logic lvl);
        return sh[1] && sh[2] && !lvl;
    endfunction

    function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                               input logic [15:0] nw,
                                               input logic [1:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = nw[7:0];
        end
        if (be[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    aseq_instr_mem u_mem (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .mem     (memBus.mem)
    );

    assign pinRaw[PIN_WR]   = !busChipSel_b && !busWrite_b;
    assign pinRaw[PIN_RD]   = !busChipSel_b && !busRead_b;
    assign pinRaw[PIN_SYNC] = syncPinIn;
    assign wrEdge   = pinRise(s.pinSh[PIN_WR], s.pinLvl[PIN_WR]);
    assign rdEdge   = pinRise(s.pinSh[PIN_RD], s.pinLvl[PIN_RD]);
    assign syncRise = pinRise(s.pinSh[PIN_SYNC], s.pinLvl[PIN_SYNC]);

    // Address and data are sampled only once the strobe has settled
    assign wordAddr = bus_address_lines[4:1];
    assign byteEn   = !bus_width_select ? 2'b11 :
                      (bus_address_lines[0] ? 2'b10 : 2'b01);
    assign wrWord   = bus_width_select ? {busDataIn[7:0], busDataIn[7:0]} : busDataIn;
    assign isInstr  = !wordAddr[3];
    assign ptr      = s.cfg[CFG_PTR +: 2];
    assign softRst  = wrEdge && wordAddr == WADDR_CFG && byteEn[0] && wrWord[CFG_RESET];
    assign statClr  = wrEdge && wordAddr == WADDR_STAT && byteEn[0];
    // An output-configured trigger pin never stalls the sequence
    assign syncWait = s.ctl[CTL_SYNC] && !s.cfg[CFG_SDIR];

    assign memBus.wrEn     = wrEdge && isInstr && ptr != SEC_NONE;
    assign memBus.wrByteEn = byteEn;
    assign memBus.wrData   = wrWord;
    assign memBus.busIdx   = wordAddr[2:0];
    assign memBus.busSec   = ptr;
    assign memBus.seqIdx   = s.idx;

    always_comb begin
        statWord = 16'h0000;
        statWord[STAT_PAUSE]   = s.pauseFlag;
        statWord[STAT_WD1]     = s.wd1Flag;
        statWord[STAT_WD2]     = s.wd2Flag;
        statWord[STAT_IDX +: 3] = s.idx;
        statWord[STAT_BUSY]    = s.st != ST_HOLD;
        if (isInstr) begin
            rdWord = memBus.busRdData;
        end else if (wordAddr == WADDR_CFG) begin
            rdWord = s.cfg;
        end else if (wordAddr == WADDR_STAT) begin
            rdWord = statWord;
        end else begin
            rdWord = 16'h0000;
        end
    end

    always_comb begin
        n = s;
        n.acqGo  = 1'b0;
        n.convGo = 1'b0;
        n.cmpGo  = 1'b0;
        for (int i = 0; i < 3; i++) begin
            n.pinSh[i] = {s.pinSh[i][1:0], pinRaw[i]};
            if (s.pinSh[i][1] == s.pinSh[i][2]) begin
                n.pinLvl[i] = s.pinSh[i][2];
            end
        end

        if (rdEdge) begin
            if (!bus_width_select) begin
                n.rdData = rdWord;
            end else if (bus_address_lines[0]) begin
                n.rdData = {8'h00, rdWord[15:8]};
            end else begin
                n.rdData = {8'h00, rdWord[7:0]};
            end
        end
        if (wrEdge && wordAddr == WADDR_CFG) begin
            n.cfg = mergeBytes(s.cfg, wrWord, byteEn);
            n.cfg[CFG_RESET] = 1'b0;
        end
        if (statClr) begin
            n.pauseFlag = s.pauseFlag && !wrWord[STAT_PAUSE];
            n.wd1Flag   = s.wd1Flag && !wrWord[STAT_WD1];
            n.wd2Flag   = s.wd2Flag && !wrWord[STAT_WD2];
        end

        case (s.st)
            ST_FETCH: begin
                n.ctl = memBus.seqCtl;
                n.st  = ST_DECIDE;
            end
            ST_DECIDE: begin
                if (s.ctl[CTL_PAUSE] && !s.firstPass) begin
                    n.cfg[CFG_START] = 1'b0;
                    n.pauseFlag      = 1'b1;
                    n.st             = ST_HOLD;
                end else if (!s.cfg[CFG_START]) begin
                    n.st = ST_HOLD;
                end else begin
                    n.firstPass = 1'b0;
                    if (s.ctl[CTL_TIMER]) begin
                        n.timer = timerPreset;
                        n.div   = 4'h0;
                        n.st    = ST_TIMER;
                    end else begin
                        n.acqGo = 1'b1;
                        n.st    = ST_ACQ;
                    end
                end
            end
            ST_HOLD: begin
                // Resume runs the held instruction without a second pause check
                if (s.cfg[CFG_START]) begin
                    n.firstPass = 1'b0;
                    if (s.ctl[CTL_TIMER]) begin
                        n.timer = timerPreset;
                        n.div   = 4'h0;
                        n.st    = ST_TIMER;
                    end else begin
                        n.acqGo = 1'b1;
                        n.st    = ST_ACQ;
                    end
                end
            end
            ST_TIMER: begin
                if (s.timer == 16'h0000) begin
                    n.acqGo = 1'b1;
                    n.st    = ST_ACQ;
                end else if (s.div == TIMER_DIV - 4'h1) begin
                    n.div   = 4'h0;
                    n.timer = s.timer - 16'h0001;
                end else begin
                    n.div = s.div + 4'h1;
                end
            end
            ST_ACQ: begin
                if (acqDone && !s.acqGo) begin
                    if (syncWait) begin
                        n.st = ST_SYNC1;
                    end else if (s.ctl[CTL_WDOG]) begin
                        n.cmpGo    = 1'b1;
                        n.cmpSel   = 1'b0;
                        n.cmpLimit = memBus.seqLim1;
                        n.st       = ST_CMP1;
                    end else begin
                        n.convGo = 1'b1;
                        n.st     = ST_CONV;
                    end
                end
            end
            ST_SYNC1: begin
                if (syncRise) begin
                    if (s.ctl[CTL_WDOG]) begin
                        n.cmpGo    = 1'b1;
                        n.cmpSel   = 1'b0;
                        n.cmpLimit = memBus.seqLim1;
                        n.st       = ST_CMP1;
                    end else begin
                        n.convGo = 1'b1;
                        n.st     = ST_CONV;
                    end
                end
            end
            ST_CMP1: begin
                if (cmpDone && !s.cmpGo) begin
                    if (cmpAbove == s.cmpLimit[LIM_DIR]) begin
                        n.wd1Flag = 1'b1;
                    end
                    if (syncWait) begin
                        n.st = ST_SYNC2;
                    end else begin
                        n.cmpGo    = 1'b1;
                        n.cmpSel   = 1'b1;
                        n.cmpLimit = memBus.seqLim2;
                        n.st       = ST_CMP2;
                    end
                end
            end
            ST_SYNC2: begin
                if (syncRise) begin
                    n.cmpGo    = 1'b1;
                    n.cmpSel   = 1'b1;
                    n.cmpLimit = memBus.seqLim2;
                    n.st       = ST_CMP2;
                end
            end
            ST_CMP2: begin
                if (cmpDone && !s.cmpGo) begin
                    if (cmpAbove == s.cmpLimit[LIM_DIR]) begin
                        n.wd2Flag = 1'b1;
                    end
                    n.st = ST_NEXT;
                end
            end
            ST_CONV: begin
                if (convDone && !s.convGo) begin
                    n.st = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (s.ctl[CTL_LOOP] || s.idx == LAST_IDX) begin
                    n.idx = 3'h0;
                end else begin
                    n.idx = s.idx + 3'h1;
                end
                n.st = ST_FETCH;
            end
            default: begin
                n.st = ST_FETCH;
            end
        endcase

        // Soft reset outranks the sequence; the host is trusted to have stopped it
        if (softRst) begin
            n.st        = ST_FETCH;
            n.idx       = 3'h0;
            n.firstPass = 1'b1;
            n.acqGo     = 1'b0;
            n.convGo    = 1'b0;
            n.cmpGo     = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s           <= '0;
            s.st        <= ST_FETCH;
            s.cfg       <= CFG_RST_VAL;
            s.firstPass <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign busDataOut = s.rdData;
    assign busDataOe  = s.pinLvl[PIN_RD];
    assign syncPinOut = s.convGo || s.cmpGo;
    assign syncPinOe  = s.cfg[CFG_SDIR];
    assign muxPos     = s.ctl[CTL_POS +: 3];
    assign muxNeg     = s.ctl[CTL_NEG +: 3];
    assign lowRes     = s.ctl[CTL_RES8];
    assign wdMode     = s.ctl[CTL_WDOG];
    assign acqGo      = s.acqGo;
    assign convGo     = s.convGo;
    assign cmpGo      = s.cmpGo;
    assign cmpLimit   = s.cmpLimit;
    assign pauseIrq   = s.pauseFlag;
    assign wdIrq      = s.wd1Flag || s.wd2Flag;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_sec_sel;
        wrEdge && isInstr |-> memBus.wrEn == (ptr != SEC_NONE) && memBus.busSec == ptr;
    endproperty
    a_sec_sel: assert property (p_sec_sel)
        else $error("Section write not steered by pointer");

    property p_byte_lanes;
        wrEdge && bus_width_select |-> byteEn[bus_address_lines[0]] && !byteEn[!bus_address_lines[0]];
    endproperty
    a_byte_lanes: assert property (p_byte_lanes)
        else $error("Byte lane does not follow address line zero");

    property p_pause_halt;
        s.st == ST_DECIDE && s.ctl[CTL_PAUSE] && !s.firstPass && !softRst
            |=> s.st == ST_HOLD && !s.cfg[CFG_START] && s.pauseFlag;
    endproperty
    a_pause_halt: assert property (p_pause_halt)
        else $error("Pause bit did not halt and flag");

    property p_first_pass;
        s.st == ST_DECIDE && s.firstPass && s.cfg[CFG_START] && !softRst && !statClr
            |=> s.st inside {ST_TIMER, ST_ACQ} && $stable(s.pauseFlag);
    endproperty
    a_first_pass: assert property (p_first_pass)
        else $error("First pass of instruction zero paused");

    property p_wrap;
        s.st == ST_NEXT && (s.ctl[CTL_LOOP] || s.idx == LAST_IDX) && !softRst
            |=> s.st == ST_FETCH && s.idx == 3'h0 ##1 (s.st == ST_DECIDE || $past(softRst));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Sequence did not return to instruction zero");

    property p_soft_reset;
        softRst |=> s.st == ST_FETCH && s.idx == 3'h0 && s.firstPass;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("Reset bit did not refetch instruction zero");

    property p_resume;
        s.st == ST_HOLD && s.cfg[CFG_START] && !softRst |=> s.st inside {ST_TIMER, ST_ACQ};
    endproperty
    a_resume: assert property (p_resume)
        else $error("Start bit did not resume");

    property p_timer_quiet;
        s.st == ST_TIMER |-> !s.convGo && !s.cmpGo && !s.acqGo;
    endproperty
    a_timer_quiet: assert property (p_timer_quiet)
        else $error("Activity during timer wait");

    property p_sync_conv;
        s.st == ST_SYNC1 && syncRise && !s.ctl[CTL_WDOG] && !softRst
            |=> s.convGo && s.st == ST_CONV;
    endproperty
    a_sync_conv: assert property (p_sync_conv)
        else $error("Trigger edge did not start conversion");

    property p_sync2_wait;
        s.st == ST_SYNC2 && !syncRise && !softRst |=> s.st == ST_SYNC2 && !s.cmpGo;
    endproperty
    a_sync2_wait: assert property (p_sync2_wait)
        else $error("Second comparison started without edge");

    property p_flag_hold;
        s.pauseFlag && !(statClr && wrWord[STAT_PAUSE]) |=> s.pauseFlag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("Pause flag lost without a clear");

    c_pause: cover property (s.st == ST_DECIDE ##1 s.st == ST_HOLD && s.pauseFlag);
    c_window: cover property (s.st == ST_CMP1 ##[1:200] s.st == ST_CMP2);
    c_loop: cover property (s.st == ST_NEXT && s.ctl[CTL_LOOP] && s.idx != 3'h0);
endmodule

// ### include/aseq_pkg.sv
// Constants, types and the bit map shared by the instruction sequencer.
// Assumes one 125 MHz clock and a host on the parallel bus pins.
// Contract
// - Eight instructions, 48 bits each, held as three 16-bit sections.
// - Config bits 9:8 pick the section: 00 control, 01 limit one, 10 limit two.
// - Word address on lines 4..1 (16-bit bus), byte address on lines 4..0 (8-bit).
// - Control bit 0 marks the last instruction; next comes instruction zero.
// - Control bit 1 halts before execution, clears start, raises pause flag.
// - Writing one to config bit 0 resumes a halted sequence.
// - Reset bit fetches instruction zero and waits for start.
// - First pass of instruction zero ignores its pause bit, no pause flag.
// - After loop or eighth instruction, zero is refetched and may pause.
// - Control bits 4:2 pick the non-inverting input.
// - Control bits 7:5 pick the inverting input; zero means ground.
// - Control bit 8 waits after acquisition for a trigger rising edge; here only with config bit 7 clear (trigger pin an input).
// - Window mode with trigger needs two edges, one per limit.
// - Control bit 9 waits for the 16-bit down timer to reach zero.
// - Control bit 10 selects eight-bit (one) or twelve-bit (zero) resolution.
// - Control bit 11 selects two limit comparisons instead of a conversion.
// - A comparison beyond a limit, per its direction bit, sets a flag.
package aseq_pkg;
    localparam int NUM_INSTR = 8;
    localparam int NUM_SEC   = 3;
    localparam logic [2:0] LAST_IDX  = 3'h7;
    localparam logic [1:0] SEC_CTL   = 2'h0;
    localparam logic [1:0] SEC_LIM1  = 2'h1;
    localparam logic [1:0] SEC_LIM2  = 2'h2;
    localparam logic [1:0] SEC_NONE  = 2'h3;
    localparam int CTL_LOOP  = 0;
    localparam int CTL_PAUSE = 1;
    localparam int CTL_POS   = 2;
    localparam int CTL_NEG   = 5;
    localparam int CTL_SYNC  = 8;
    localparam int CTL_TIMER = 9;
    localparam int CTL_RES8  = 10;
    localparam int CTL_WDOG  = 11;
    localparam int LIM_DIR   = 9;
    localparam int CFG_START = 0;
    localparam int CFG_RESET = 1;
    localparam int CFG_SDIR  = 7;
    localparam int CFG_PTR   = 8;
    localparam int STAT_PAUSE = 0;
    localparam int STAT_WD1   = 1;
    localparam int STAT_WD2   = 2;
    localparam int STAT_IDX   = 4;
    localparam int STAT_BUSY  = 8;
    localparam logic [3:0] WADDR_CFG  = 4'h8;
    localparam logic [3:0] WADDR_STAT = 4'h9;
    localparam logic [15:0] CFG_RST_VAL = 16'h0000;
    localparam logic [3:0] TIMER_DIV  = 4'h8;
    localparam int PIN_WR   = 0;
    localparam int PIN_RD   = 1;
    localparam int PIN_SYNC = 2;
    typedef enum logic [3:0] {
        ST_FETCH, ST_DECIDE, ST_HOLD, ST_TIMER, ST_ACQ, ST_SYNC1,
        ST_CMP1, ST_SYNC2, ST_CMP2, ST_CONV, ST_NEXT
    } aseq_state_t;
endpackage

// ### include/aseq_mem_if.sv
// Link between the sequencer and its instruction store.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface aseq_mem_if;
    logic        wrEn;
    logic [1:0]  wrByteEn;
    logic [15:0] wrData;
    logic [2:0]  busIdx;
    logic [1:0]  busSec;
    logic [15:0] busRdData;
    logic [2:0]  seqIdx;
    logic [15:0] seqCtl;
    logic [15:0] seqLim1;
    logic [15:0] seqLim2;
    modport mem (input wrEn, wrByteEn, wrData, busIdx, busSec, seqIdx,
                 output busRdData, seqCtl, seqLim1, seqLim2);
    modport ctl (output wrEn, wrByteEn, wrData, busIdx, busSec, seqIdx,
                 input busRdData, seqCtl, seqLim1, seqLim2);
endinterface

// ### src/aseq_instr_mem.sv
// Instruction store: eight instructions of three 16-bit sections.
// Assumes the sequencer masks section code 3 on its own side as well.
`timescale 1ns/10ps
module aseq_instr_mem
    import aseq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    aseq_mem_if.mem  mem
);
    typedef struct packed {
        logic [NUM_INSTR-1:0][NUM_SEC-1:0][15:0] word;
    } aseq_mem_t;

    aseq_mem_t s;
    aseq_mem_t n;

    always_comb begin
        n = s;
        if (mem.wrEn && mem.busSec != SEC_NONE) begin
            for (int b = 0; b < 2; b++) begin
                if (mem.wrByteEn[b]) begin
                    n.word[mem.busIdx][mem.busSec][b*8 +: 8] = mem.wrData[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Section code 3 holds nothing and reads as zero
    assign mem.busRdData = (mem.busSec == SEC_NONE) ? 16'h0000 :
                           s.word[mem.busIdx][mem.busSec];
    assign mem.seqCtl    = s.word[mem.seqIdx][SEC_CTL];
    assign mem.seqLim1   = s.word[mem.seqIdx][SEC_LIM1];
    assign mem.seqLim2   = s.word[mem.seqIdx][SEC_LIM2];
endmodule

// ### tb/aseq_engine_model.sv
// Analog engine stand-in: answers each go pulse after a fixed delay.
// Assumes one-cycle go pulses from the sequencer.
`timescale 1ns/10ps
module aseq_engine_model #(
    parameter int DLY = 3
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic acqGo,
    input  wire logic convGo,
    input  wire logic cmpGo,
    output logic      acqDone,
    output logic      convDone,
    output logic      cmpDone,
    output logic      cmpAbove
);
    logic [DLY-1:0] acqSh_q;
    logic [DLY-1:0] convSh_q;
    logic [DLY-1:0] cmpSh_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acqSh_q  <= '0;
            convSh_q <= '0;
            cmpSh_q  <= '0;
            cmpAbove <= 1'b0;
        end else begin
            acqSh_q  <= {acqSh_q[DLY-2:0], acqGo};
            convSh_q <= {convSh_q[DLY-2:0], convGo};
            cmpSh_q  <= {cmpSh_q[DLY-2:0], cmpGo};
            // Result only means something with done; elsewhere it wanders
            cmpAbove <= cmpSh_q[DLY-2] ? 1'b1 : ~cmpAbove;
        end
    end
    assign acqDone  = acqSh_q[DLY-1];
    assign convDone = convSh_q[DLY-1];
    assign cmpDone  = cmpSh_q[DLY-1];
endmodule

// ### tb/test_aseq_sequencer.sv
// Self-checking bench for the instruction sequencer over its parallel bus.
// Assumes the engine model answers every go pulse.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_aseq_sequencer
    import aseq_pkg::*;
;
    logic        clk_sys = 0, rst_b = 0, busChipSel_b = 1, busRead_b = 1, busWrite_b = 1;
    logic        bus_width_select = 0, syncPinIn = 0, trigOn = 0;
    logic [4:0]  bus_address_lines = '0;
    logic [15:0] busDataIn = '0, busDataOut, rd, cmpLimit;
    logic        busDataOe, syncPinOut, syncPinOe, lowRes, wdMode, acqGo, acqDone, convGo;
    logic        convDone, cmpGo, cmpDone, cmpAbove, pauseIrq, wdIrq;
    logic [2:0]  muxPos, muxNeg;
    logic [7:0]  acqLog[$];
    logic [15:0] limLog[$];
    int          compares = 0, miscompares = 0, convCnt = 0, cycles = 0, pinCnt = 0;
    always #4 clk_sys = ~clk_sys;
    aseq_sequencer aseq_sequencer_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .busChipSel_b(busChipSel_b), .busRead_b(busRead_b), .busWrite_b(busWrite_b),
        .bus_width_select(bus_width_select), .bus_address_lines(bus_address_lines),
        .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
        .syncPinIn(syncPinIn), .syncPinOut(syncPinOut), .syncPinOe(syncPinOe),
        .timerPreset(16'h0003), .muxPos(muxPos), .muxNeg(muxNeg), .lowRes(lowRes),
        .wdMode(wdMode), .acqGo(acqGo), .acqDone(acqDone), .convGo(convGo),
        .convDone(convDone), .cmpGo(cmpGo), .cmpLimit(cmpLimit), .cmpDone(cmpDone),
        .cmpAbove(cmpAbove), .pauseIrq(pauseIrq), .wdIrq(wdIrq));
    aseq_engine_model aseq_engine_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .acqGo(acqGo), .convGo(convGo), .cmpGo(cmpGo), .acqDone(acqDone),
        .convDone(convDone), .cmpDone(cmpDone), .cmpAbove(cmpAbove));
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Strobes pass a 3-stage sync, so each phase is held well past that
    task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        busChipSel_b      <= 1'b0;
        busWrite_b        <= ~wr;
        busRead_b         <= wr;
        bus_address_lines <= a;
        busDataIn         <= d;
        repeat (6) @(posedge clk_sys);
        if (!wr) `CHK("read enable", 1'b1, busDataOe)
        busChipSel_b <= 1'b1;
        busWrite_b   <= 1'b1;
        busRead_b    <= 1'b1;
        repeat (6) @(posedge clk_sys);
        if (!wr) `CHK("read released", 1'b0, busDataOe)
        rd = busDataOut;
    endtask
    always @(negedge clk_sys) begin
        cycles++;
        if (acqGo) acqLog.push_back({wdMode, lowRes, muxNeg, muxPos});
        if (syncPinOut) pinCnt++;
        if (cmpGo) limLog.push_back(cmpLimit);
        if (convGo) convCnt++;
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end
    // Trigger pin is free-running while enabled; rising edge every 20 clocks
    always @(posedge clk_sys) if (trigOn && cycles % 10 == 0) syncPinIn <= ~syncPinIn;
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        acc(0, {WADDR_CFG, 1'b0}, '0);
        `CHK("cfg reset", 16'h0000, rd)
        for (int s = 0; s < 3; s++) begin
            acc(1, {WADDR_CFG, 1'b0}, {6'h00, s[1:0], 8'h00});
            for (int i = 0; i < 8; i++) begin
                acc(1, {i[3:0], 1'b0}, {s[3:0], i[3:0], 8'h5a});
            end
        end
        for (int s = 0; s < 3; s++) begin
            acc(1, {WADDR_CFG, 1'b0}, {6'h00, s[1:0], 8'h00});
            for (int i = 7; i >= 0; i--) begin
                acc(0, {i[3:0], 1'b0}, '0);
                `CHK("instr section", {s[3:0], i[3:0], 8'h5a}, rd)
            end
        end
        acc(1, {WADDR_CFG, 1'b0}, 16'h0300);
        acc(0, 5'h00, '0);
        `CHK("pointer three", 16'h0000, rd)
        acc(0, {4'ha, 1'b0}, '0);
        `CHK("unmapped word", 16'h0000, rd)
        acc(1, {WADDR_CFG, 1'b0}, 16'h0000);
        bus_width_select <= 1'b1;
        acc(1, 5'h06, 16'h0034);
        acc(1, 5'h07, 16'h0012);
        acc(0, 5'h07, '0);
        `CHK("byte high", 16'h0012, rd)
        bus_width_select <= 1'b0;
        acc(0, 5'h06, '0);
        `CHK("word join", 16'h1234, rd)
        // Instruction zero waits on the timer and on a trigger edge before converting
        acc(1, 5'h00, 16'h07ae);
        acc(1, 5'h02, 16'h0905);
        acc(1, {WADDR_CFG, 1'b0}, 16'h0100);
        acc(1, 5'h02, 16'h0211);
        acc(1, {WADDR_CFG, 1'b0}, 16'h0200);
        acc(1, 5'h02, 16'h0022);
        acc(1, {WADDR_CFG, 1'b0}, 16'h0002);
        acc(0, {WADDR_STAT, 1'b0}, '0);
        `CHK("idle status", 16'h0000, rd)
        trigOn <= 1'b1;
        acc(1, {WADDR_CFG, 1'b0}, 16'h0001);
        `CHK("timer hold", 0, acqLog.size())
        for (int k = 0; k < 3000 && pauseIrq !== 1'b1; k++) @(posedge clk_sys);
        `CHK("acq count", 2, acqLog.size())
        `CHK("first fields", 8'h6b, acqLog[0])
        `CHK("second fields", 8'h81, acqLog[1])
        `CHK("limit one", 16'h0211, limLog[0])
        `CHK("limit two", 16'h0022, limLog[1])
        `CHK("conv count", 1, convCnt)
        `CHK("trigger out", 3, pinCnt)
        `CHK("trigger dir", 1'b0, syncPinOe)
        `CHK("wd irq", 1'b1, wdIrq)
        acc(0, {WADDR_STAT, 1'b0}, '0);
        `CHK("paused status", 16'h0003, rd)
        acc(0, {WADDR_CFG, 1'b0}, '0);
        `CHK("start cleared", 16'h0000, rd)
        acc(1, {WADDR_STAT, 1'b0}, 16'h0001);
        `CHK("pause cleared", 1'b0, pauseIrq)
        acc(1, {WADDR_CFG, 1'b0}, 16'h0001);
        for (int k = 0; k < 3000 && acqLog.size() < 3; k++) @(posedge clk_sys);
        `CHK("resumed fields", 8'h6b, acqLog[2])
        // Reset and start together: first pass runs from the fetch step
        acc(1, {WADDR_CFG, 1'b0}, 16'h0003);
        for (int k = 0; k < 3000 && acqLog.size() < 4; k++) @(posedge clk_sys);
        `CHK("restart fields", 8'h6b, acqLog[3])
        `CHK("restart no pause", 1'b0, pauseIrq)
        acc(1, {WADDR_CFG, 1'b0}, 16'h0002);
        summarize();
    end
endmodule
